/* sslg_regs.sv */
// Register bank: line offset, split-screen height, colour table, pins.
// Assumes an APB master on pclk; general-purpose pins arrive async.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module sslg_regs
  import sslg_pkg::*;
(
  input  wire logic        pclk,          // Register clock, 100 MHz.
  input  wire logic        presetn,       // Async reset, active low.
  input  wire logic        pclk_en,       // Clock enable.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB access phase.
  input  wire logic        pwrite,        // APB direction.
  input  wire logic [31:0] paddr,         // APB byte address.
  input  wire logic [31:0] pwdata,        // APB write data.
  input  wire logic [3:0]  pstrb,         // APB byte strobes.
  output logic [31:0]      prdata,        // APB read data.
  output logic             pready,        // APB ready.
  output logic             pslverr,       // APB error, unmapped.
  input  wire logic [4:0]  general_purpose_pin_in,  // Pin levels.
  output logic [4:0]       general_purpose_pin_out, // Pin drive.
  output logic [4:0]       general_purpose_pin_oe,  // Pin enable.
  input  wire logic        panel_data_upper_bits_en,// Pins used as data.
  output sslg_pkg::sslg_fetch_cfg_t fetch_cfg,      // Fetch settings.
  input  wire logic        lut_rd_sel,    // Fetch reads the table.
  input  wire logic [7:0]  lut_rd_addr,   // Fetch entry.
  output logic [11:0]      lut_rd_rgb     // Fetch colour.
);
  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SSLG_IDLE, SSLG_WAIT, SSLG_DONE} sslg_st_t;
  sslg_st_t st_reg;
  sslg_st_t st_next;

  wire       setup   = psel && !penable;
  wire       wr_lane = pstrb[0];
  wire [7:0] widx    = paddr[SSLG_WORD_SHIFT +: 8];
  wire       aligned = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0);
  wire       hit_s2l = aligned && widx == SSLG_IDX_SCR2_START_LO;
  wire       hit_s2h = aligned && widx == SSLG_IDX_SCR2_START_HI;
  wire       hit_off = aligned && widx == SSLG_IDX_LINE_OFFSET;
  wire       hit_hl  = aligned && widx == SSLG_IDX_HEIGHT_LO;
  wire       hit_hh  = aligned && widx == SSLG_IDX_HEIGHT_HI;
  wire       hit_ix  = aligned && widx == SSLG_IDX_TABLE_INDEX;
  wire       hit_val = aligned && widx == SSLG_IDX_TABLE_VALUE;
  wire       hit_dir = aligned && widx == SSLG_IDX_PIN_DIR;
  wire       hit_pin = aligned && widx == SSLG_IDX_PIN_STATE;
  wire       hit_md  = aligned && widx == SSLG_IDX_MODE;
  wire       hit_any = hit_s2l | hit_s2h | hit_off | hit_hl | hit_hh |
                       hit_ix | hit_val | hit_dir | hit_pin | hit_md;

  // Registers act once, in the setup cycle; the access cycle only answers.
  wire       act = pclk_en && setup && (st_reg == SSLG_IDLE);
  wire       wr  = act && pwrite && wr_lane;

  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      SSLG_IDLE: if (setup) st_next = SSLG_WAIT;
      SSLG_WAIT: st_next = SSLG_DONE;
      SSLG_DONE: st_next = SSLG_IDLE;
      default:   st_next = SSLG_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [15:0] scr2_reg;
  logic [7:0]  offset_reg;
  logic [9:0]  height_reg;
  logic        rot_reg;
  logic [4:0]  dir_reg;
  logic [4:0]  pin_wr_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scr2_reg   <= {2{SSLG_RST_BYTE}};
      offset_reg <= SSLG_RST_BYTE;
      height_reg <= SSLG_RST_HEIGHT;
      rot_reg    <= 1'b0;
      dir_reg    <= SSLG_RST_PINS;
      pin_wr_reg <= SSLG_RST_PINS;
    end
    else if (wr)
    begin
      if (hit_s2l) scr2_reg[7:0]    <= pwdata[7:0];
      if (hit_s2h) scr2_reg[15:8]   <= pwdata[7:0];
      if (hit_off) offset_reg       <= pwdata[7:0];
      if (hit_hl)  height_reg[7:0]  <= pwdata[7:0];
      if (hit_hh)  height_reg[9:8]  <= pwdata[SSLG_HEIGHT_HI_W-1:0];
      if (hit_md)  rot_reg          <= pwdata[SSLG_MODE_ROT_BIT];
      if (hit_dir) dir_reg          <= pwdata[SSLG_PIN_N-1:0];
      if (hit_pin) pin_wr_reg       <= pwdata[SSLG_PIN_N-1:0];
    end
  end

  // ------------------------------------------------------------
  // Colour table pointer, staging and commit
  // ------------------------------------------------------------
  logic [7:0]   ptr_reg;
  logic [1:0]   comp_reg;
  logic [3:0]   red_reg;
  logic [3:0]   grn_reg;
  sslg_lut_wr_t lut_wr_reg;
  logic [11:0]  lut_q;

  wire data_acc = act && hit_val;
  wire data_wr  = data_acc && pwrite && wr_lane;
  wire last_c   = comp_reg == SSLG_COMP_BLUE;
  wire [3:0] wnib = pwdata[SSLG_LUT_DATA_LSB +: SSLG_LUT_W];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ptr_reg    <= SSLG_RST_BYTE;
      comp_reg   <= SSLG_COMP_RED;
      red_reg    <= 4'h0;
      grn_reg    <= 4'h0;
      lut_wr_reg <= '0;
    end
    else if (pclk_en)
    begin
      lut_wr_reg.we <= 1'b0;
      if (act && hit_ix && pwrite && wr_lane)
      begin
        ptr_reg  <= pwdata[7:0];
        comp_reg <= SSLG_COMP_RED;
      end
      else if (data_acc)
      begin
        comp_reg <= last_c ? SSLG_COMP_RED : comp_reg + 2'h1;
        if (last_c) ptr_reg <= ptr_reg + 8'h01;
        if (data_wr && comp_reg == SSLG_COMP_RED)   red_reg <= wnib;
        if (data_wr && comp_reg == SSLG_COMP_GREEN) grn_reg <= wnib;
        if (data_wr && last_c)
        begin
          lut_wr_reg <= '{we: 1'b1, addr: ptr_reg,
                          rgb: {red_reg, grn_reg, wnib}};
        end
      end
    end
  end

  wire [7:0] lut_addr = lut_rd_sel ? lut_rd_addr : ptr_reg;

  sslg_lut u_lut (
    .pclk    (pclk),
    .pclk_en (pclk_en),
    .wr      (lut_wr_reg),
    .rd_addr (lut_addr),
    .rd_rgb  (lut_q)
  );

  wire [3:0] lut_nib = (comp_reg == SSLG_COMP_RED)   ? lut_q[11:8] :
                       (comp_reg == SSLG_COMP_GREEN) ? lut_q[7:4]  :
                                                       lut_q[3:0];

  // ------------------------------------------------------------
  // General-purpose pins
  // ------------------------------------------------------------
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  wire  [4:0] pin_state;

  genvar g;
  generate
    for (g = 0; g < SSLG_PIN_N; g++)
    begin : g_pin
      assign pin_state[g] = dir_reg[g] ? pin_wr_reg[g]
                                       : pin_s2_reg[g];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_reg              <= SSLG_RST_PINS;
      pin_s2_reg              <= SSLG_RST_PINS;
      general_purpose_pin_out <= SSLG_RST_PINS;
      general_purpose_pin_oe  <= SSLG_RST_PINS;
    end
    else if (pclk_en)
    begin
      pin_s1_reg              <= general_purpose_pin_in;
      pin_s2_reg              <= pin_s1_reg;
      general_purpose_pin_out <= pin_wr_reg;
      general_purpose_pin_oe  <= panel_data_upper_bits_en ?
                                 SSLG_RST_PINS : dir_reg;
    end
  end

  // ------------------------------------------------------------
  // Read data and answer
  // ------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit_s2l) rd_byte = scr2_reg[7:0];
    if (hit_s2h) rd_byte = scr2_reg[15:8];
    if (hit_off) rd_byte = offset_reg;
    if (hit_hl)  rd_byte = height_reg[7:0];
    if (hit_hh)  rd_byte = {6'h00, height_reg[9:8]};
    if (hit_ix)  rd_byte = ptr_reg;
    if (hit_val) rd_byte = {lut_nib, 4'h0};
    if (hit_dir) rd_byte = {3'h0, dir_reg};
    if (hit_pin) rd_byte = {3'h0, pin_state};
    if (hit_md)  rd_byte = {rot_reg, 7'h00};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg    <= SSLG_IDLE;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      fetch_cfg <= '0;
      lut_rd_rgb <= 12'h000;
    end
    else if (pclk_en)
    begin
      st_reg  <= st_next;
      pready  <= (st_next == SSLG_DONE);
      if (act)
      begin
        prdata  <= {24'h00_0000, rd_byte};
        pslverr <= !hit_any;
      end
      fetch_cfg.landscape      <= !rot_reg;
      fetch_cfg.line_offset    <= rot_reg ? 8'h00 : offset_reg;
      fetch_cfg.screen2_start  <= rot_reg ? 16'h0000 : scr2_reg;
      fetch_cfg.screen1_height <= height_reg;
      lut_rd_rgb <= lut_q;
    end
  end
endmodule
`default_nettype wire

/* sslg_pkg.sv */
// Package of constants and carrier types for the split-screen, colour table
// and pin-direction register bank.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package sslg_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] SSLG_IDX_SCR2_START_LO = 8'h0E;
  localparam logic [7:0] SSLG_IDX_SCR2_START_HI = 8'h0F;
  localparam logic [7:0] SSLG_IDX_LINE_OFFSET   = 8'h11;
  localparam logic [7:0] SSLG_IDX_HEIGHT_LO     = 8'h12;
  localparam logic [7:0] SSLG_IDX_HEIGHT_HI     = 8'h13;
  localparam logic [7:0] SSLG_IDX_TABLE_INDEX   = 8'h15;
  localparam logic [7:0] SSLG_IDX_TABLE_VALUE   = 8'h17;
  localparam logic [7:0] SSLG_IDX_PIN_DIR       = 8'h18;
  localparam logic [7:0] SSLG_IDX_PIN_STATE     = 8'h19;
  localparam logic [7:0] SSLG_IDX_MODE          = 8'h1B;
  localparam int         SSLG_WORD_SHIFT        = 2;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int SSLG_HEIGHT_W     = 10;
  localparam int SSLG_HEIGHT_HI_W  = 2;
  localparam int SSLG_PIN_N        = 5;
  localparam int SSLG_LUT_W        = 4;
  localparam int SSLG_LUT_DEPTH    = 256;
  localparam int SSLG_LUT_DATA_LSB = 4;
  localparam int SSLG_MODE_ROT_BIT = 7;

  // ----------------------------------------------------------------
  // Reset values and colour component codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  SSLG_RST_BYTE   = 8'h00;
  localparam logic [9:0]  SSLG_RST_HEIGHT = 10'h3FF;
  localparam logic [4:0]  SSLG_RST_PINS   = 5'h00;
  localparam logic [1:0]  SSLG_COMP_RED   = 2'h0;
  localparam logic [1:0]  SSLG_COMP_GREEN = 2'h1;
  localparam logic [1:0]  SSLG_COMP_BLUE  = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        landscape;
    logic [15:0] screen2_start;
    logic [7:0]  line_offset;
    logic [9:0]  screen1_height;
  } sslg_fetch_cfg_t;

  typedef struct packed {
    logic        we;
    logic [7:0]  addr;
    logic [11:0] rgb;
  } sslg_lut_wr_t;

endpackage

/* sslg_lut.sv */
// Colour table storage: one 256-entry table of 12-bit red, green, blue values.
// Assumes single-clock writes and an asynchronous read port.
`timescale 1ns/1ps
`default_nettype none
module sslg_lut
  import sslg_pkg::*;
(
  input  wire logic                 pclk,     // Register clock.
  input  wire logic                 pclk_en,  // Freezes storage when low.
  input  wire sslg_pkg::sslg_lut_wr_t wr,     // Whole-entry write.
  input  wire logic [7:0]           rd_addr,  // Read entry.
  output logic [11:0]               rd_rgb    // Red, green, blue.
);
  logic [11:0] mem [SSLG_LUT_DEPTH];

  always_ff @(posedge pclk)
  begin
    if (pclk_en && wr.we)
    begin
      mem[wr.addr] <= wr.rgb;
    end
  end

  assign rd_rgb = mem[rd_addr];
endmodule
`default_nettype wire

/* sslg_pin_model.sv */
// Far-side model of the five general-purpose pins.
// Assumes the bank's enable is high while it drives a pin.
`timescale 1ns/1ps
`default_nettype none
module sslg_pin_model
(
  input  wire logic [4:0] pin_oe,  // Bank drives pin.
  input  wire logic [4:0] pin_out, // Bank level.
  input  wire logic [4:0] ext_lvl, // Outside level.
  output logic [4:0]      pin_lvl  // Wire level.
);
  // A wire shows the bank's level where enabled, else the outside one.
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

/* sslg_regs_chk.sv */
// Checker for the bank's bus answers, pin enables and fetch settings.
// Assumes it is bound to sslg_regs with pclk_en held high.
`timescale 1ns/1ps
`default_nettype none
module sslg_regs_chk
  import sslg_pkg::*;
(
  input wire logic        pclk,                     // Clock.
  input wire logic        presetn,                  // Reset.
  input wire logic        psel,                     // Select.
  input wire logic        penable,                  // Access.
  input wire logic [31:0] paddr,                    // Address.
  input wire logic [31:0] prdata,                   // Read data.
  input wire logic        pready,                   // Ready.
  input wire logic        pslverr,                  // Error.
  input wire logic        panel_data_upper_bits_en, // Pins as data.
  input wire logic [4:0]  general_purpose_pin_oe,   // Pin enable.
  input wire sslg_pkg::sslg_fetch_cfg_t fetch_cfg   // Settings.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  chk_ready_lat: assert property (s_setup |=> s_answer)
    else $error("answer not two cycles after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_unmap_err: assert property (s_setup ##0 paddr == 32'h0000_0068
    |=> s_answer ##0 pslverr)
    else $error("unmapped access not refused");
  chk_data_ok: assert property (
    s_setup ##0 paddr == 32'h0000_005c |-> ##2 pready && !pslverr)
    else $error("table data access refused");
  chk_oe_panel: assert property (
    panel_data_upper_bits_en [*2] |-> general_purpose_pin_oe == 5'h00)
    else $error("pin driven while used as panel data");
  chk_rot_cfg: assert property (!fetch_cfg.landscape |->
    fetch_cfg.line_offset == 8'h00 && fetch_cfg.screen2_start == 16'h0000)
    else $error("offset or second start used while rotated");
  chk_rdata_hold: assert property (!pready && !$rose(penable) |->
    $stable(prdata))
    else $error("read data changed outside an answer");
  chk_height_rst: assert property ($rose(presetn) |=>
    fetch_cfg.screen1_height == SSLG_RST_HEIGHT)
    else $error("height not at reset value");
endmodule
bind sslg_regs sslg_regs_chk u_chk (.pclk, .presetn, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .panel_data_upper_bits_en,
  .general_purpose_pin_oe, .fetch_cfg);
`default_nettype wire

/* tb_sslg_regs.sv */
// Self-checking bench for the register bank over APB.
// Assumes the package, pin model and bank are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_sslg_regs;
  import sslg_pkg::*;
  logic            pclk, presetn, psel, penable, pwrite, panel_en, err;
  logic [31:0]     paddr, pwdata, prdata, rd;
  logic            pready, pslverr;
  logic [4:0]      pin_lvl, pin_out, pin_oe, ext_lvl;
  logic            en, lsel;
  logic [3:0]      strb;
  logic [7:0]      laddr;
  logic [11:0]     lrgb;
  sslg_fetch_cfg_t cfg;
  int              num_errors, tests_run, cyc;

  sslg_regs DUT (.pclk, .presetn, .pclk_en(en), .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb(strb), .prdata, .pready, .pslverr,
    .general_purpose_pin_in(pin_lvl), .general_purpose_pin_out(pin_out),
    .general_purpose_pin_oe(pin_oe), .panel_data_upper_bits_en(panel_en),
    .fetch_cfg(cfg), .lut_rd_sel(lsel), .lut_rd_addr(laddr),
    .lut_rd_rgb(lrgb));
  sslg_pin_model u_pins (.pin_oe, .pin_out, .ext_lvl, .pin_lvl);

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request holds until ready is sampled high.
  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [7:0] exp);
    apb(1'b0, i, 8'h00);
    chk(rd[15:0], {8'h00, exp});
  endtask

  initial
  begin
    num_errors = 0;
    tests_run = 0;
    cyc = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    panel_en = 1'b0;
    en = 1'b1;
    strb = 4'hf;
    lsel = 1'b0;
    laddr = 8'h00;
    ext_lvl = 5'h0a;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(SSLG_IDX_HEIGHT_LO, 8'hff);
    rdc(SSLG_IDX_HEIGHT_HI, 8'h03);
    rdc(SSLG_IDX_PIN_DIR, 8'h00);
    wr(SSLG_IDX_HEIGHT_LO, 8'hce);
    wr(SSLG_IDX_HEIGHT_HI, 8'h00);
    chk(16'(cfg.screen1_height), 16'h00ce);
    wr(SSLG_IDX_LINE_OFFSET, 8'h5a);
    wr(SSLG_IDX_SCR2_START_LO, 8'h34);
    wr(SSLG_IDX_SCR2_START_HI, 8'h12);
    chk(16'(cfg.line_offset), 16'h005a);
    chk(cfg.screen2_start, 16'h1234);
    strb <= 4'he;
    wr(SSLG_IDX_LINE_OFFSET, 8'h11);
    strb <= 4'hf;
    rdc(SSLG_IDX_LINE_OFFSET, 8'h5a);
    wr(SSLG_IDX_HEIGHT_HI, 8'h03);
    wr(SSLG_IDX_MODE, 8'h80);
    chk(16'(cfg.line_offset), 16'h0000);
    chk(cfg.screen2_start, 16'h0000);
    wr(SSLG_IDX_MODE, 8'h00);
    wr(SSLG_IDX_TABLE_INDEX, 8'h05);
    for (int i = 1; i < 7; i++)
      wr(SSLG_IDX_TABLE_VALUE, {i[3:0], 4'hf});
    wr(SSLG_IDX_TABLE_INDEX, 8'h05);
    for (int i = 1; i < 7; i++)
      rdc(SSLG_IDX_TABLE_VALUE, {i[3:0], 4'h0});
    rdc(SSLG_IDX_TABLE_INDEX, 8'h07);
    wr(SSLG_IDX_TABLE_INDEX, 8'h06);
    wr(SSLG_IDX_TABLE_VALUE, 8'hf0);
    wr(SSLG_IDX_TABLE_VALUE, 8'hf0);
    wr(SSLG_IDX_TABLE_INDEX, 8'h06);
    rdc(SSLG_IDX_TABLE_VALUE, 8'h40);
    lsel <= 1'b1;
    laddr <= 8'h05;
    repeat (2) @(posedge pclk);
    chk(16'(lrgb), 16'h0123);
    en <= 1'b0;
    laddr <= 8'h06;
    repeat (3) @(posedge pclk);
    chk(16'(lrgb), 16'h0123);
    en <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(16'(lrgb), 16'h0456);
    lsel <= 1'b0;
    wr(SSLG_IDX_PIN_DIR, 8'h15);
    wr(SSLG_IDX_PIN_STATE, 8'h05);
    rdc(SSLG_IDX_PIN_DIR, 8'h15);
    chk(16'(pin_oe), 16'h0015);
    chk(16'(pin_out & 5'h15), 16'h0005);
    rdc(SSLG_IDX_PIN_STATE, 8'h0f);
    panel_en <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(16'(pin_oe), 16'h0000);
    panel_en <= 1'b0;
    apb(1'b0, 8'h1a, 8'h00);
    chk(16'(err), 16'h0001);
    wr(SSLG_IDX_TABLE_VALUE, 8'h00);
    chk(16'(err), 16'h0000);
    results();
  end
endmodule
`default_nettype wire
